// ==== core/porseq_top.sv ====
`timescale 1ns/1ns
// Behaviour
// - Hold reset until supply rises past threshold
// - Assert reset while supply below fall threshold
// - Power-on reset zeroes source and power-up status
// - Other resets set own source flag only; pin reset sets none
// - First release, monitor on: long processing
// - First release, monitor off: processing time
// - Later releases, monitor on: processing time
// - Later releases, monitor off: processing time
// - Processing covers oscillator accuracy wait
// - Start on fast on-chip clock, software selectable
// - Low-voltage interrupt sets level and mode bits
// - Monitor power-up processing after high level
// - Monitor-only reset recovery processing time
// - Interrupt mode uses monitor reset power-up delay
// - Power-up flag accepts one, ignores zero
// - Source flags clear on eight-bit read
module porseq_top
  import porseq_pkg::*;
#(
  parameter int FIRST_MON_CYC = porseq_pkg::CYC_FIRST_MON,
  parameter int FIRST_NOMON_CYC = porseq_pkg::CYC_FIRST_NOMON,
  parameter int LATER_MON_CYC = porseq_pkg::CYC_LATER_MON,
  parameter int LATER_NOMON_CYC = porseq_pkg::CYC_LATER_NOMON,
  parameter int MON_PROC_CYC = porseq_pkg::CYC_MON_PROC,
  parameter int MON_RECOV_CYC = porseq_pkg::CYC_MON_RECOV,
  parameter int STAB_CYC = porseq_pkg::CYC_STAB
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic SUPPLY_RISE_OK,
  input wire logic SUPPLY_FALL_LOW,
  input wire logic EXT_RESET_B,
  input wire logic MONITOR_ENABLE,
  input wire logic MONITOR_LEVEL_OK,
  input wire logic MONITOR_RESET,
  input wire logic [1:0] MONITOR_MODE,
  input wire logic LOW_VOLTAGE_IRQ,
  input wire logic WDOG_RESET,
  input wire logic ILLINSN_RESET,
  input wire logic PARITY_RESET,
  input wire logic ILLMEM_RESET,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic INT_RESET_B,
  output logic CPU_RUN,
  output logic [2:0] CPU_CLK_SEL,
  output logic OSC_ACCURACY_WAIT
);
  logic [5:0] async_raw;
  logic [5:0] async_sync;
  logic rise_ok;
  logic fall_low;
  logic ext_rst_b;
  logic mon_ok;
  logic mon_rst;
  logic lv_irq;
  logic [1:0] lv_irq_d;
  logic lv_irq_q;
  logic lv_irq_rise;
  logic ext_rel_q;
  logic ext_rel_edge;
  logic por_cond;
  logic core_rst_src;
  logic [7:0] src_q;
  logic [7:0] src_d;
  logic [7:0] src_set;
  logic pwr_q;
  logic [7:0] mon_ctrl_q;
  logic [2:0] clk_sel_q;
  logic seen_ext_q;
  logic mon_only_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] proc_len;
  logic [CNT_W-1:0] mon_len;
  logic cnt_done;
  logic [7:0] rdata_d;
  logic wr_src;
  logic wr_pwr;
  logic wr_mon;
  logic wr_clk;
  logic rd_src;
  porseq_state_e state_q;
  porseq_state_e state_d;

  assign async_raw = {LOW_VOLTAGE_IRQ, MONITOR_RESET, MONITOR_LEVEL_OK, EXT_RESET_B, SUPPLY_FALL_LOW,
                      SUPPLY_RISE_OK};

  porseq_sync #(.W(6)) u_sync (
    .SYS_CLK(SYS_CLK),
    .RST_B(RST_B),
    .async_in(async_raw),
    .sync_out(async_sync)
  );

  assign rise_ok = async_sync[0];
  assign fall_low = async_sync[1];
  assign ext_rst_b = async_sync[2];
  assign mon_ok = async_sync[3] | ~MONITOR_ENABLE;
  assign mon_rst = async_sync[4] & MONITOR_ENABLE;
  assign lv_irq = async_sync[5];

  // Fall comparator wins over rise so a brown-out always resets
  assign por_cond = fall_low | ~rise_ok;
  assign core_rst_src = WDOG_RESET | ILLINSN_RESET | PARITY_RESET | ILLMEM_RESET;

  assign lv_irq_rise = lv_irq & ~lv_irq_q;
  assign ext_rel_edge = ext_rst_b & ~ext_rel_q;

  // Processing length: first release after POR vs later, monitor in use or not
  assign proc_len = !seen_ext_q ?
                    (MONITOR_ENABLE ? CNT_W'(FIRST_MON_CYC) : CNT_W'(FIRST_NOMON_CYC)) :
                    (MONITOR_ENABLE ? CNT_W'(LATER_MON_CYC) : CNT_W'(LATER_NOMON_CYC));
  // Interrupt mode takes the same start delay as reset mode
  assign mon_len = mon_only_q ? CNT_W'(MON_RECOV_CYC) : CNT_W'(MON_PROC_CYC);
  assign cnt_done = (cnt_q == '0);

  assign wr_src = REG_WR & (REG_ADDR == REG_RESET_SRC);
  assign wr_pwr = REG_WR & (REG_ADDR == REG_PWRUP_STAT);
  assign wr_mon = REG_WR & (REG_ADDR == REG_MON_CTRL);
  assign wr_clk = REG_WR & (REG_ADDR == REG_CLK_SEL);
  assign rd_src = REG_RD & (REG_ADDR == REG_RESET_SRC);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PS_POR: if (!por_cond) state_d = PS_STAB;
      PS_STAB: if (cnt_done) state_d = PS_EXTHOLD;
      PS_EXTHOLD: if (ext_rel_edge) state_d = PS_PROC;
      PS_PROC: if (cnt_done) state_d = MONITOR_ENABLE ? PS_MONHOLD : PS_RUN;
      PS_MONHOLD: if (mon_ok) state_d = PS_MONPROC;
      PS_MONPROC: if (cnt_done) state_d = PS_RUN;
      PS_RUN: begin
        if (!ext_rst_b) state_d = PS_EXTHOLD;
        else if (mon_rst) state_d = PS_MONHOLD;
        else if (core_rst_src) state_d = PS_EXTHOLD;
      end
      default: state_d = PS_POR;
    endcase
    if (por_cond) state_d = PS_POR;
    else if (!ext_rst_b && state_q != PS_POR && state_q != PS_STAB) state_d = PS_EXTHOLD;
  end

  // Flags held by other sources, own flag set
  always_comb begin
    src_set = ZERO8;
    src_set[SRC_MON] = mon_rst & (state_q == PS_RUN);
    src_set[SRC_WDOG] = WDOG_RESET;
    src_set[SRC_ILLINSN] = ILLINSN_RESET;
    src_set[SRC_PARITY] = PARITY_RESET;
    src_set[SRC_ILLMEM] = ILLMEM_RESET;
  end
  // Clear on read, but a new event in that cycle survives
  assign src_d = ((rd_src ? ZERO8 : src_q) | src_set) & SRC_MASK;

  always_comb begin
    unique case (REG_ADDR)
      REG_RESET_SRC: rdata_d = src_q;
      REG_PWRUP_STAT: rdata_d = {7'h00, pwr_q};
      REG_MON_CTRL: rdata_d = mon_ctrl_q;
      REG_CLK_SEL: rdata_d = {5'h00, clk_sel_q};
      REG_SEQ_STAT: rdata_d = {2'h0, seen_ext_q, mon_only_q, 1'b0, state_q};
      default: rdata_d = ZERO8;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_q <= PS_POR;
      cnt_q <= '0;
      lv_irq_q <= 1'b0;
      ext_rel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lv_irq_q <= lv_irq;
      ext_rel_q <= ext_rst_b;
      if (state_d != state_q) begin
        unique case (state_d)
          PS_STAB: cnt_q <= CNT_W'(STAB_CYC);
          PS_PROC: cnt_q <= proc_len;
          PS_MONPROC: cnt_q <= mon_len;
          default: cnt_q <= '0;
        endcase
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      src_q <= ZERO8;
      pwr_q <= 1'b0;
      seen_ext_q <= 1'b0;
      mon_only_q <= 1'b0;
    end else if (state_q == PS_POR) begin
      src_q <= ZERO8;
      pwr_q <= 1'b0;
      seen_ext_q <= 1'b0;
      mon_only_q <= 1'b0;
    end else begin
      src_q <= wr_src ? (REG_WDATA & SRC_MASK) | src_set : src_d;
      if (wr_pwr && REG_WDATA[0]) pwr_q <= 1'b1;
      if (state_q == PS_PROC && cnt_done) seen_ext_q <= 1'b1;
      if (state_q == PS_RUN && mon_rst) mon_only_q <= 1'b1;
      else if (state_q == PS_EXTHOLD) mon_only_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      mon_ctrl_q <= ZERO8;
      clk_sel_q <= CLK_HS_ONCHIP;
      REG_RDATA <= ZERO8;
      INT_RESET_B <= 1'b0;
      CPU_RUN <= 1'b0;
      CPU_CLK_SEL <= CLK_HS_ONCHIP;
      OSC_ACCURACY_WAIT <= 1'b0;
    end else begin
      if (lv_irq_rise) begin
        mon_ctrl_q <= mon_ctrl_q | (ZERO8 | (8'h01 << MON_LEVEL_BIT) | (8'h01 << MON_MODE_BIT));
      end else if (wr_mon) begin
        mon_ctrl_q <= REG_WDATA;
      end
      // Any reset returns the CPU to the fast on-chip clock
      if (state_q != PS_RUN) clk_sel_q <= CLK_HS_ONCHIP;
      else if (wr_clk && REG_WDATA[2:0] <= CLK_LOW_ONCHIP) clk_sel_q <= REG_WDATA[2:0];
      REG_RDATA <= REG_RD ? rdata_d : ZERO8;
      INT_RESET_B <= (state_d == PS_RUN);
      CPU_RUN <= (state_d == PS_RUN);
      // Follows the run flag so a leaving CPU never shows a stale clock choice
      CPU_CLK_SEL <= (state_d != PS_RUN) ? CLK_HS_ONCHIP : clk_sel_q;
      OSC_ACCURACY_WAIT <= (state_d == PS_PROC);
    end
  end

  assign lv_irq_d = {MONITOR_MODE == MODE_INTR, 1'b0};

  a_fall_reset: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    fall_low |=> !INT_RESET_B)
    else $error("internal reset not asserted on supply fall");
  a_por_clears: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state_q == PS_POR |=> (src_q == ZERO8) && !pwr_q)
    else $error("power-on reset did not clear status");
  a_src_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    WDOG_RESET && state_q != PS_POR |=> src_q[SRC_WDOG])
    else $error("watchdog flag not set");
  a_read_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rd_src && !(|src_set) && !por_cond && state_q != PS_POR |=> src_q == ZERO8)
    else $error("source flags not cleared by read");
  a_pwr_zero_ign: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    pwr_q && state_q != PS_POR |=> pwr_q)
    else $error("power-up flag lost without power-on reset");
  a_lvirq_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    lv_irq_rise |=> mon_ctrl_q[MON_LEVEL_BIT] && mon_ctrl_q[MON_MODE_BIT])
    else $error("level or mode bit not set on interrupt");
  a_proc_load: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state_q == PS_EXTHOLD && state_d == PS_PROC && !seen_ext_q && MONITOR_ENABLE
    |=> cnt_q == CNT_W'(FIRST_MON_CYC))
    else $error("wrong first processing time");
  a_clk_default: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !CPU_RUN |-> CPU_CLK_SEL == CLK_HS_ONCHIP)
    else $error("CPU clock not on fast on-chip oscillator in reset");
  a_rise_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !rise_ok |=> !INT_RESET_B [*2])
    else $error("reset released before supply rise");
  c_first_run: cover property (@(posedge SYS_CLK) disable iff (!RST_B) !seen_ext_q ##1 seen_ext_q);
  c_mon_recov: cover property (@(posedge SYS_CLK) disable iff (!RST_B) state_q == PS_MONPROC && mon_only_q);
  c_src_read: cover property (@(posedge SYS_CLK) disable iff (!RST_B) rd_src && src_q != ZERO8);
  c_intr_mode: cover property (@(posedge SYS_CLK) disable iff (!RST_B) lv_irq_d[1] && state_q == PS_MONPROC);
endmodule // porseq_top

// ==== core/porseq_pkg.sv ====
package porseq_pkg;
  // Register port map (byte-style indices)
  localparam logic [3:0] REG_RESET_SRC = 4'h0;
  localparam logic [3:0] REG_PWRUP_STAT = 4'h1;
  localparam logic [3:0] REG_MON_CTRL = 4'h2;
  localparam logic [3:0] REG_CLK_SEL = 4'h3;
  localparam logic [3:0] REG_SEQ_STAT = 4'h4;

  // Reset source flag bit positions
  localparam int SRC_MON = 0;
  localparam int SRC_ILLMEM = 1;
  localparam int SRC_PARITY = 2;
  localparam int SRC_WDOG = 4;
  localparam int SRC_ILLINSN = 7;
  localparam logic [7:0] SRC_MASK = 8'h97;

  // Monitor control bits
  localparam int MON_LEVEL_BIT = 0;
  localparam int MON_MODE_BIT = 7;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Clock selection codes
  localparam logic [2:0] CLK_HS_ONCHIP = 3'h0;
  localparam logic [2:0] CLK_HS_SYSTEM = 3'h1;
  localparam logic [2:0] CLK_SUBSYS = 3'h2;
  localparam logic [2:0] CLK_MID_ONCHIP = 3'h3;
  localparam logic [2:0] CLK_LOW_ONCHIP = 3'h4;

  // Mode option codes {hi,lo}
  localparam logic [1:0] MODE_INTR = 2'h1;

  // Processing times in nanoseconds, maximum figures
  localparam int CLK_NS = 10;
  localparam int T_FIRST_MON_NS = 832000;
  localparam int T_FIRST_NOMON_NS = 519000;
  localparam int T_LATER_MON_NS = 675000;
  localparam int T_LATER_NOMON_NS = 362000;
  localparam int T_MON_PROC_NS = 70100;
  localparam int T_MON_RECOV_NS = 70100;
  localparam int T_STAB_NS = 10000;
  localparam int CYC_FIRST_MON = T_FIRST_MON_NS / CLK_NS;
  localparam int CYC_FIRST_NOMON = T_FIRST_NOMON_NS / CLK_NS;
  localparam int CYC_LATER_MON = T_LATER_MON_NS / CLK_NS;
  localparam int CYC_LATER_NOMON = T_LATER_NOMON_NS / CLK_NS;
  localparam int CYC_MON_PROC = T_MON_PROC_NS / CLK_NS;
  localparam int CYC_MON_RECOV = T_MON_RECOV_NS / CLK_NS;
  localparam int CYC_STAB = (T_STAB_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W = 17;

  typedef enum logic [2:0] {
    PS_POR = 3'b000,
    PS_STAB = 3'b001,
    PS_EXTHOLD = 3'b011,
    PS_PROC = 3'b010,
    PS_RUN = 3'b110,
    PS_MONHOLD = 3'b111,
    PS_MONPROC = 3'b101
  } porseq_state_e;
endpackage

// ==== core/porseq_sync.sv ====
`timescale 1ns/1ns
module porseq_sync #(
  parameter int W = 2
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // Stage one feeds stage two only
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // porseq_sync

// ==== dv/porseq_board.sv ====
`timescale 1ns/1ns
module porseq_board (
  input wire logic clk,
  input wire logic supply_up,
  input wire logic pin_up,
  input wire logic mon_up,
  output logic rise_ok,
  output logic fall_low,
  output logic ext_reset_b,
  output logic level_ok
);
  logic [2:0] good_q = 3'h0;
  always @(posedge clk) begin
    if (!supply_up)
      good_q <= 3'h0;
    else if (good_q != 3'h4)
      good_q <= good_q + 3'h1;
  end
  // Comparators switch off the clock edge, as real analog levels would
  assign #3 rise_ok = supply_up;
  assign #3 fall_low = !supply_up;
  assign #3 level_ok = supply_up && mon_up;
  // Board keeps the pin low until the rail has settled
  assign #3 ext_reset_b = pin_up && good_q == 3'h4;
endmodule // porseq_board

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import porseq_pkg::*;
  localparam int P_FM = 40;
  localparam int P_FN = 30;
  localparam int P_LM = 35;
  localparam int P_LN = 25;
  localparam int P_MP = 10;
  localparam int P_MR = 10;
  localparam int P_ST = 20;
  // Row: write flag, address, write data, expected read
  localparam logic [20:0] ROWS [10] = '{
    {1'b1, REG_PWRUP_STAT, 8'h00, 8'h00}, {1'b1, REG_PWRUP_STAT, 8'h01, 8'h01},
    {1'b1, REG_PWRUP_STAT, 8'h00, 8'h01}, {1'b1, REG_CLK_SEL, 8'h01, 8'h01},
    {1'b1, REG_CLK_SEL, 8'h02, 8'h02}, {1'b1, REG_CLK_SEL, 8'h03, 8'h03},
    {1'b1, REG_CLK_SEL, 8'h04, 8'h04}, {1'b1, REG_CLK_SEL, 8'h05, 8'h04},
    {1'b1, REG_CLK_SEL, 8'h00, 8'h00}, {1'b1, 4'h9, 8'h5a, 8'h00}};
  localparam logic [7:0] SRC_BIT [4] = '{8'(1 << SRC_ILLMEM), 8'(1 << SRC_PARITY),
    8'(1 << SRC_ILLINSN), 8'(1 << SRC_WDOG)};
  localparam logic [1:0] MODES [2] = '{2'h3, MODE_INTR};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_up = 1'b0;
  logic pin_up = 1'b0;
  logic mon_up = 1'b0;
  logic mon_en = 1'b0;
  logic mon_rst = 1'b0;
  logic lv_irq = 1'b0;
  logic [1:0] mon_mode = 2'h3;
  logic [3:0] src = 4'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rise_ok, fall_low, ext_b, level_ok, int_rst_b, cpu_run, acc_wait;
  logic [7:0] rdata;
  logic [2:0] clk_sel;
  int num_errors = 0;
  int checked = 0;
  always #5 sys_clk = ~sys_clk;

  porseq_board porseq_board_inst (.clk(sys_clk), .supply_up(supply_up), .pin_up(pin_up), .mon_up(mon_up),
    .rise_ok(rise_ok), .fall_low(fall_low), .ext_reset_b(ext_b), .level_ok(level_ok));
  porseq_top #(.FIRST_MON_CYC(P_FM), .FIRST_NOMON_CYC(P_FN), .LATER_MON_CYC(P_LM), .LATER_NOMON_CYC(P_LN),
    .MON_PROC_CYC(P_MP), .MON_RECOV_CYC(P_MR), .STAB_CYC(P_ST)) porseq_top_inst (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .SUPPLY_RISE_OK(rise_ok), .SUPPLY_FALL_LOW(fall_low),
    .EXT_RESET_B(ext_b), .MONITOR_ENABLE(mon_en), .MONITOR_LEVEL_OK(level_ok), .MONITOR_RESET(mon_rst),
    .MONITOR_MODE(mon_mode), .LOW_VOLTAGE_IRQ(lv_irq), .WDOG_RESET(src[3]), .ILLINSN_RESET(src[2]),
    .PARITY_RESET(src[1]), .ILLMEM_RESET(src[0]), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .INT_RESET_B(int_rst_b), .CPU_RUN(cpu_run), .CPU_CLK_SEL(clk_sel),
    .OSC_ACCURACY_WAIT(acc_wait));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  // Window allows for the input synchronisers and the release register
  task automatic rel_time(input string what, input int lo, input int hi, output logic w);
    int c;
    c = 0;
    w = 1'b0;
    while (int_rst_b !== 1'b1 && c < hi + 40) begin
      @(posedge sys_clk);
      #1 c++;
      if (acc_wait === 1'b1) w = 1'b1;
    end
    chk(what, lo, (c >= lo && c <= hi) ? lo : c);
  endtask
  task automatic meas(input string what, input int lo, input int hi);
    logic w;
    @(posedge sys_clk);
    pin_up <= 1'b1;
    rel_time(what, lo, hi, w);
    chk("osc wait", 1, w);
    chk("cpu clock", CLK_HS_ONCHIP, clk_sel);
    chk("cpu run", 1, cpu_run);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    cyc(20000);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    test_done();
  end

  initial begin
    logic w;
    cyc(8);
    rst_b <= 1'b1;
    #1 chk("reset out", 0, int_rst_b);
    rd_reg(REG_RESET_SRC, 8'h00, "flags");
    rd_reg(REG_PWRUP_STAT, 8'h00, "power-up status");
    cyc(30);
    #1 chk("held low supply", 0, int_rst_b);
    @(posedge sys_clk);
    supply_up <= 1'b1;
    cyc(P_ST + 20);
    meas("first no-mon", P_FN, P_FN + 8);
    // Software waits out the crystal settle time before any row picks the system clock
    cyc(P_ST);
    foreach (ROWS[i]) begin
      if (ROWS[i][20]) wr_reg(ROWS[i][19:16], ROWS[i][15:8]);
      rd_reg(ROWS[i][19:16], ROWS[i][7:0], "register row");
      if (ROWS[i][19:16] == REG_CLK_SEL) chk("cpu clock row", ROWS[i][2:0], clk_sel);
    end
    $display("test power-up and registers done");
    // A non-default clock must fall back to the fast on-chip clock through the reset
    wr_reg(REG_CLK_SEL, 8'h03);
    @(posedge sys_clk);
    pin_up <= 1'b0;
    cyc(5);
    #1 chk("pin reset", 0, int_rst_b);
    meas("later no-mon", P_LN, P_LN + 8);
    @(posedge sys_clk);
    lv_irq <= 1'b1;
    cyc(4);
    rd_reg(REG_MON_CTRL, 8'h81, "monitor ctrl");
    @(posedge sys_clk);
    lv_irq <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      src <= 4'h1 << i;
      @(posedge sys_clk);
      src <= 4'h0;
      cyc(4);
      #1 chk("core reset", 0, int_rst_b);
      rd_reg(REG_RESET_SRC, SRC_BIT[i], "source flag");
      rd_reg(REG_RESET_SRC, 8'h00, "flags after read");
      @(posedge sys_clk);
      pin_up <= 1'b0;
      cyc(3);
      meas("after core reset", P_LN, P_LN + 8);
    end
    rd_reg(REG_PWRUP_STAT, 8'h01, "power-up kept");
    $display("test core resets done");
    // Flag left set on purpose so that the supply loss has something to clear
    @(posedge sys_clk);
    src <= 4'h8;
    @(posedge sys_clk);
    src <= 4'h0;
    cyc(4);
    supply_up <= 1'b0;
    cyc(4);
    rd_reg(REG_RESET_SRC, 8'h00, "flags on fall");
    rd_reg(REG_PWRUP_STAT, 8'h00, "power-up on fall");
    foreach (MODES[m]) begin
      @(posedge sys_clk);
      mon_en <= 1'b1;
      mon_mode <= MODES[m];
      mon_up <= 1'b1;
      pin_up <= 1'b0;
      supply_up <= 1'b1;
      cyc(P_ST + 20);
      meas("first mon", P_FM, P_FM + P_MP + 8);
      @(posedge sys_clk);
      mon_rst <= 1'b1;
      mon_up <= 1'b0;
      cyc(5);
      #1 chk("monitor reset", 0, int_rst_b);
      rd_reg(REG_RESET_SRC, 8'(1 << SRC_MON), "monitor flag");
      @(posedge sys_clk);
      mon_rst <= 1'b0;
      mon_up <= 1'b1;
      rel_time("monitor recovery", P_MR, P_MR + 8, w);
      @(posedge sys_clk);
      pin_up <= 1'b0;
      cyc(5);
      meas("later mon", P_LM, P_LM + P_MR + 8);
      @(posedge sys_clk);
      supply_up <= 1'b0;
      cyc(4);
      #1 chk("supply fall", 0, int_rst_b);
    end
    $display("test monitor modes done");
    test_done();
  end
endmodule // testbench
